// File: logic/chgreg_pkg.sv
`default_nettype none
package chgreg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_STATE   = 9'h0d3;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 9'h0d4;
  localparam logic [ADDR_W-1:0] OFS_CURRENT = 9'h0d5;
  localparam logic [ADDR_W-1:0] OFS_VOLTAGE = 9'h0d6;
  localparam logic [ADDR_W-1:0] OFS_PROTECT = 9'h0d7;
  localparam logic [ADDR_W-1:0] OFS_PROTECTION_COMMAND_SPARE = 9'h0d9;
  localparam logic [ADDR_W-1:0] OFS_WDCLR   = 9'h0da;
  localparam logic [ADDR_W-1:0] OFS_TIMER   = 9'h0db;
  localparam logic [ADDR_W-1:0] OFS_DISCHARGE_CONTROL = 9'h0dc;
  localparam logic [ADDR_W-1:0] OFS_EXTCTL  = 9'h1d1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_STATE   = 8'h00;
  localparam logic [DATA_W-1:0] RST_CONTROL = 8'ha1;
  localparam logic [DATA_W-1:0] RST_CURRENT = 8'h00;
  localparam logic [DATA_W-1:0] RST_VOLTAGE = 8'h07;
  localparam logic [DATA_W-1:0] RST_PROTECT = 8'h3c;
  localparam logic [DATA_W-1:0] RST_TIMER   = 8'h03;
  localparam logic [DATA_W-1:0] RST_DISCHARGE_CONTROL = 8'h04;
  localparam logic [DATA_W-1:0] RST_EXTCTL  = 8'h13;

  // ****************************************************************
  // Implemented bit masks; all other bits ignore writes, read zero
  // ****************************************************************
  localparam logic [DATA_W-1:0] MSK_STATE   = 8'h0f;
  localparam logic [DATA_W-1:0] MSK_CONTROL = 8'hef;
  localparam logic [DATA_W-1:0] MSK_CURRENT = 8'h7f;
  localparam logic [DATA_W-1:0] MSK_VOLTAGE = 8'h0f;
  localparam logic [DATA_W-1:0] MSK_PROTECT = 8'hfc;
  localparam logic [DATA_W-1:0] MSK_TIMER   = 8'h0f;
  localparam logic [DATA_W-1:0] MSK_DISCHARGE_CONTROL = 8'h04;
  localparam logic [DATA_W-1:0] MSK_EXTCTL  = 8'h7f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CTL_ENABLE_N  = 0;
  localparam int unsigned CTL_TRICKLE   = 1;
  localparam int unsigned CTL_WDT_EN    = 2;
  localparam int unsigned CTL_POLICY    = 3;
  localparam int unsigned CTL_HOST_A    = 5;
  localparam int unsigned CTL_ISOLATE   = 6;
  localparam int unsigned CTL_HOST_B    = 7;
  localparam int unsigned CUR_CC_LSB    = 0;
  localparam int unsigned CUR_EOC_LSB   = 4;
  localparam int unsigned VLT_CV_LSB    = 0;
  localparam int unsigned PRT_WDT_LSB   = 2;
  localparam int unsigned PRT_OV_LSB    = 4;
  localparam int unsigned PRT_ILIM_LSB  = 6;
  localparam int unsigned TMR_SEL_LSB   = 0;
  localparam int unsigned DIS_THERM_EN  = 2;
  localparam int unsigned EXT_BYPASS    = 0;
  localparam int unsigned EXT_COIN_EN   = 1;
  localparam int unsigned EXT_COIN_LSB  = 2;
  localparam int unsigned EXT_SLOW_SEL  = 5;
  localparam int unsigned EXT_BUCK_DIS  = 6;

  // ****************************************************************
  // Charger state codes
  // ****************************************************************
  typedef enum logic [3:0] {
    CHGREG_ST_BATTERY   = 4'h0,
    CHGREG_ST_STANDBY   = 4'h1,
    CHGREG_ST_ADAPT_OVP = 4'h2,
    CHGREG_ST_DETECT    = 4'h3,
    CHGREG_ST_PRECHG1   = 4'h4,
    CHGREG_ST_SUSPEND   = 4'h5,
    CHGREG_ST_STOP1     = 4'h6,
    CHGREG_ST_QUICK     = 4'h7,
    CHGREG_ST_PRECHG2   = 4'h8,
    CHGREG_ST_STOP2     = 4'h9,
    CHGREG_ST_CONST_V   = 4'ha,
    CHGREG_ST_STOP3     = 4'hb,
    CHGREG_ST_STOP4     = 4'hc,
    CHGREG_ST_STOP5     = 4'hd,
    CHGREG_ST_FORCED    = 4'he,
    CHGREG_ST_RESERVED  = 4'hf
  } chgreg_state_t;

  // Decoded settings handed to the analog charger
  typedef struct packed {
    logic       charger_on;                // Charger running
    logic       forced_trickle;            // Trickle forced
    logic       charge_watchdog_enable;    // Watchdog on
    logic       state_change_irq_policy;   // 1: every state change
    logic       main_fet_allow;            // Main FET may conduct
    logic       bypass_fet_allow;          // Bypass FET may conduct
    logic [1:0] host_mode_sel;             // {ctl_b, ctl_a}
    logic [3:0] const_current_setpoint;    // 200 mA + 100 mA/code
    logic [2:0] end_of_charge_current;     // 40 mA + 40 mA/code
    logic [3:0] max_charge_voltage;        // 4.025 V + 25 mV/code
    logic [1:0] watchdog_period_sel;       // 20/40/80/160 s
    logic [1:0] battery_ov_margin;         // 75/100/150/200 mV
    logic [1:0] input_current_limit;       // 100/500/1000/1800 mA
    logic [3:0] safety_time_sel;           // 1 h + 1 h/code
    logic       thermistor_block_enable;   // NTC block on
    logic       backup_cell_charge_enable; // Coin charger on
    logic [2:0] backup_cell_voltage_sel;   // 2.5 V .. 3.3 V
    logic       slow_charge_current_sel;   // 0: 40 mA, 1: 80 mA
    logic       charger_converter_enable;  // Buck running
  } chgreg_cfg_t;

endpackage
`default_nettype wire

// File: logic/chgreg_top.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module chgreg_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys, // System clock
  input  wire logic         nrst,    // Sync reset, low
  input  wire logic [W-1:0] pin,     // Asynchronous inputs
  output logic      [W-1:0] level    // Filtered levels
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  // Chain; first stage read only by the second
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a bit only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      level_q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s2_q[i];
        end
      end
    end
  end

  assign level = level_q;

endmodule

// ****************************************************************
// Charger register bank
// ****************************************************************
// Operation
// - Read-only 4-bit charger state code in bits 3:0; 0xF reserved.
// - Control bit 0 is active-low charger enable; control resets to 0xA1.
// - Control bit 1 forces trickle charging; zero lets it happen automatically.
// - Control bit 2 enables the charge watchdog timer.
// - Control bit 3 picks completion flag: cycle complete, or every state change.
// - Control bit 6 forces main and bypass FETs off, isolating battery.
// - Current bits 3:0 set charge current 200 to 1700 mA; reset 0x00.
// - Current bits 6:4 set end-of-charge current 40 to 320 mA.
// - Voltage bits 3:0 set max charge voltage 4.025 to 4.400 V; reset 0x07.
// - Protection bits 3:2 pick watchdog period 20 to 160 s; reset 0x3C.
// - Protection bits 5:4 pick battery overvoltage margin 75 to 200 mV.
// - Protection bits 7:6 pick buck input current limit 100 to 1800 mA.
// - Timer bits 3:0 pick safety time 1 to 16 h; reset 0x03.
// - Discharge bit 2 enables thermistor block; resets to 0x04.
// - Extended bit 0 makes bypass FET used and controllable; reset 0x13.
// - Extended bit 1 enables coin cell charger, on by default.
// - Extended bits 4:2 set coin cell voltage 2.5 to 3.3 V.
// - Extended bit 5 picks trickle current 40 or 80 mA.
// - Extended bit 6 disables the charger buck converter when set.
// - Control bits 5 and 7 ignored by charger, decoded for host mode.
// - Policy zero: completion only when battery above CV and current below EOC.
// - Temperature out of window while charging stops charge and flags fault.
module chgreg_top
  import chgreg_pkg::*;
(
  input  wire logic              clk_sys,          // 20 MHz core clock
  input  wire logic              nrst,             // Sync reset, low
  input  wire logic [ADDR_W-1:0] reg_addr,         // Register address
  input  wire logic              reg_wr,           // Write strobe
  input  wire logic [DATA_W-1:0] reg_wdata,        // Write data
  input  wire logic              reg_rd,           // Read strobe
  output logic      [DATA_W-1:0] reg_rdata,        // Read data, held
  output logic                   reg_rvalid,       // Read data ready
  input  wire logic [3:0]        charger_state_in, // Charger FSM state
  input  wire logic              vbat_above_cv,    // Comparator pin
  input  wire logic              ichg_below_eoc,   // Comparator pin
  input  wire logic              temp_out_window,  // NTC window pin
  output chgreg_cfg_t            cfg,              // Decoded settings
  output logic                   charge_stop,      // Thermal stop
  output logic                   comp_event,       // Completion pulse
  output logic                   temp_event        // Thermal fault pulse
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [DATA_W-1:0] control_q;
  logic [DATA_W-1:0] current_q;
  logic [DATA_W-1:0] voltage_q;
  logic [DATA_W-1:0] protect_q;
  logic [DATA_W-1:0] timer_q;
  logic [DATA_W-1:0] discharge_control_q;
  logic [DATA_W-1:0] extctl_q;
  logic [DATA_W-1:0] state_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              rvalid_q;
  logic [2:0]        pins_s;
  logic              done_cond_q;
  logic              temp_fault_q;
  logic              stop_q;
  logic              comp_q;
  logic              temp_ev_q;
  logic              charging;
  logic              done_cond;
  logic              temp_fault;
  chgreg_cfg_t       cfg_q;

  // ****************************************************************
  // Analog status inputs
  // ****************************************************************
  // Comparator outputs are asynchronous to the core clock
  chgreg_sync #(
    .W (3)
  ) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     ({temp_out_window, ichg_below_eoc, vbat_above_cv}),
    .level   (pins_s)
  );

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Masked writes keep unimplemented bits at zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      control_q <= RST_CONTROL;
    end else if (reg_wr && reg_addr == OFS_CONTROL) begin
      control_q <= reg_wdata & MSK_CONTROL;
    end
  end

  // Current setpoints
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      current_q <= RST_CURRENT;
    end else if (reg_wr && reg_addr == OFS_CURRENT) begin
      current_q <= reg_wdata & MSK_CURRENT;
    end
  end

  // Voltage setpoint
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      voltage_q <= RST_VOLTAGE;
    end else if (reg_wr && reg_addr == OFS_VOLTAGE) begin
      voltage_q <= reg_wdata & MSK_VOLTAGE;
    end
  end

  // Protection settings
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      protect_q <= RST_PROTECT;
    end else if (reg_wr && reg_addr == OFS_PROTECT) begin
      protect_q <= reg_wdata & MSK_PROTECT;
    end
  end

  // Safety timer selection
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      timer_q <= RST_TIMER;
    end else if (reg_wr && reg_addr == OFS_TIMER) begin
      timer_q <= reg_wdata & MSK_TIMER;
    end
  end

  // Discharge control, thermistor only
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      discharge_control_q <= RST_DISCHARGE_CONTROL;
    end else if (reg_wr && reg_addr == OFS_DISCHARGE_CONTROL) begin
      discharge_control_q <= reg_wdata & MSK_DISCHARGE_CONTROL;
    end
  end

  // Extended charger control
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      extctl_q <= RST_EXTCTL;
    end else if (reg_wr && reg_addr == OFS_EXTCTL) begin
      extctl_q <= reg_wdata & MSK_EXTCTL;
    end
  end

  // Snapshot of the charger state; writes never reach it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= RST_STATE;
    end else begin
      state_q <= {4'h0, charger_state_in} & MSK_STATE;
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Spare command registers and unmapped addresses answer zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      OFS_STATE:   rdata_d = state_q;
      OFS_CONTROL: rdata_d = control_q;
      OFS_CURRENT: rdata_d = current_q;
      OFS_VOLTAGE: rdata_d = voltage_q;
      OFS_PROTECT: rdata_d = protect_q;
      OFS_TIMER:   rdata_d = timer_q;
      OFS_DISCHARGE_CONTROL: rdata_d = discharge_control_q;
      OFS_EXTCTL:  rdata_d = extctl_q;
      default:     rdata_d = 8'h00;
    endcase
  end

  // Read data is captured once and held until the next read
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ****************************************************************
  // Charger events
  // ****************************************************************
  // Charging states keep the NTC check active regardless of enable
  always_comb begin
    case (chgreg_state_t'(state_q[3:0]))
      CHGREG_ST_PRECHG1: charging = 1'b1;
      CHGREG_ST_QUICK:   charging = 1'b1;
      CHGREG_ST_PRECHG2: charging = 1'b1;
      CHGREG_ST_CONST_V: charging = 1'b1;
      default:           charging = 1'b0;
    endcase
  end

  assign done_cond  = pins_s[0] & pins_s[1];
  assign temp_fault = pins_s[2] & charging;

  // Edge history for the event detectors
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      done_cond_q  <= 1'b0;
      temp_fault_q <= 1'b0;
    end else begin
      done_cond_q  <= done_cond;
      temp_fault_q <= temp_fault;
    end
  end

  // Completion pulse follows the selected policy
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      comp_q <= 1'b0;
    end else if (control_q[CTL_POLICY]) begin
      comp_q <= (state_q[3:0] != charger_state_in);
    end else begin
      comp_q <= done_cond & ~done_cond_q;
    end
  end

  // Thermal stop holds while the window pin stays high, even after charging ends; pulse on entry
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stop_q    <= 1'b0;
      temp_ev_q <= 1'b0;
    end else begin
      stop_q    <= temp_fault | (stop_q & pins_s[2]);
      temp_ev_q <= temp_fault & ~temp_fault_q;
    end
  end

  // ****************************************************************
  // Decoded settings
  // ****************************************************************
  // Registered so the analog side never sees decode glitches
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cfg_q <= '0;
    end else begin
      cfg_q.charger_on <= ~control_q[CTL_ENABLE_N] & ~stop_q;
      cfg_q.forced_trickle <= control_q[CTL_TRICKLE];
      cfg_q.charge_watchdog_enable <= control_q[CTL_WDT_EN];
      cfg_q.state_change_irq_policy <= control_q[CTL_POLICY];
      cfg_q.main_fet_allow <= ~control_q[CTL_ISOLATE];
      cfg_q.bypass_fet_allow <= ~control_q[CTL_ISOLATE]
                                & extctl_q[EXT_BYPASS];
      cfg_q.host_mode_sel <= {control_q[CTL_HOST_B],
                              control_q[CTL_HOST_A]};
      cfg_q.const_current_setpoint <= current_q[CUR_CC_LSB +: 4];
      cfg_q.end_of_charge_current <= current_q[CUR_EOC_LSB +: 3];
      cfg_q.max_charge_voltage <= voltage_q[VLT_CV_LSB +: 4];
      cfg_q.watchdog_period_sel <= protect_q[PRT_WDT_LSB +: 2];
      cfg_q.battery_ov_margin <= protect_q[PRT_OV_LSB +: 2];
      cfg_q.input_current_limit <= protect_q[PRT_ILIM_LSB +: 2];
      cfg_q.safety_time_sel <= timer_q[TMR_SEL_LSB +: 4];
      cfg_q.thermistor_block_enable <= discharge_control_q[DIS_THERM_EN];
      cfg_q.backup_cell_charge_enable <= extctl_q[EXT_COIN_EN];
      cfg_q.backup_cell_voltage_sel <= extctl_q[EXT_COIN_LSB +: 3];
      cfg_q.slow_charge_current_sel <= extctl_q[EXT_SLOW_SEL];
      cfg_q.charger_converter_enable <= ~extctl_q[EXT_BUCK_DIS];
    end
  end

  assign reg_rdata   = rdata_q;
  assign reg_rvalid  = rvalid_q;
  assign cfg         = cfg_q;
  assign charge_stop = stop_q;
  assign comp_event  = comp_q;
  assign temp_event  = temp_ev_q;

endmodule
`default_nettype wire

// File: tb/chgreg_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port-level checks of the charger register bank
// ****************************************************************
module chgreg_properties
  import chgreg_pkg::*;
(
  input wire logic              clk_sys,          // Clock
  input wire logic              nrst,             // Sync reset, low
  input wire logic [ADDR_W-1:0] reg_addr,         // Address
  input wire logic              reg_wr,           // Write strobe
  input wire logic [DATA_W-1:0] reg_wdata,        // Write data
  input wire logic              reg_rd,           // Read strobe
  input wire logic [DATA_W-1:0] reg_rdata,        // Read data
  input wire logic              reg_rvalid,       // Read valid
  input wire logic [3:0]        charger_state_in, // State code in
  input wire logic              vbat_above_cv,    // Comparator
  input wire logic              ichg_below_eoc,   // Comparator
  input wire logic              temp_out_window,  // NTC window
  input wire chgreg_cfg_t       cfg,              // Settings
  input wire logic              charge_stop,      // Thermal stop
  input wire logic              comp_event,       // Completion pulse
  input wire logic              temp_event        // Thermal pulse
);

  // Readable bits of the last read target; unmapped places read zero
  logic [DATA_W-1:0] mask_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mask_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_STATE:   mask_q <= 8'h0f;
        OFS_CONTROL: mask_q <= 8'hef;
        OFS_CURRENT: mask_q <= 8'h7f;
        OFS_VOLTAGE: mask_q <= 8'h0f;
        OFS_PROTECT: mask_q <= 8'hfc;
        OFS_TIMER:   mask_q <= 8'h0f;
        OFS_DISCHARGE_CONTROL: mask_q <= 8'h04;
        OFS_EXTCTL:  mask_q <= 8'h7f;
        default:     mask_q <= 8'h00;
      endcase
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Control writes; a second write right after would move cfg again
  sequence ctl_write;
    reg_wr && reg_addr == OFS_CONTROL;
  endsequence
  sequence ctl_quiet;
    !(reg_wr && reg_addr == OFS_CONTROL);
  endsequence

  rvalid_pulse_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read valid does not follow the read strobe");
  rdata_hold_a: assert property ($changed(reg_rdata) |-> reg_rvalid)
    else $error("read data changed without a read");
  reserved_zero_a: assert property (reg_rvalid |-> (reg_rdata & ~mask_q) == 8'h00)
    else $error("reserved bits read as one");
  state_read_a: assert property (reg_rd && reg_addr == OFS_STATE |=>
    reg_rdata == {4'h0, $past(charger_state_in, 2)})
    else $error("state code read back wrong");
  ctl_decode_a: assert property (ctl_write ##1 ctl_quiet |=>
    cfg.forced_trickle == $past(reg_wdata[1], 2)
    && cfg.charge_watchdog_enable == $past(reg_wdata[2], 2)
    && cfg.state_change_irq_policy == $past(reg_wdata[3], 2)
    && cfg.main_fet_allow == !$past(reg_wdata[6], 2)
    && cfg.host_mode_sel == {$past(reg_wdata[7], 2), $past(reg_wdata[5], 2)})
    else $error("control fields decoded wrong");
  enable_on_a: assert property ((ctl_write and !reg_wdata[0]) ##1 (ctl_quiet and !charge_stop)
    |=> cfg.charger_on)
    else $error("charger not on after enable write");
  stop_blocks_a: assert property (charge_stop |=> !cfg.charger_on)
    else $error("charger on during thermal stop");
  temp_pulse_a: assert property (temp_event |-> charge_stop ##1 !temp_event)
    else $error("thermal fault pulse without stop");
  temp_quiet_a: assert property (!temp_out_window [*8] |-> !temp_event)
    else $error("thermal fault with window pin low");
  state_event_a: assert property (charger_state_in != $past(charger_state_in)
    ##1 cfg.state_change_irq_policy |-> comp_event)
    else $error("no completion pulse on state change");

endmodule

`default_nettype wire

// File: tb/test_charger_control_regs.sv
`timescale 1ns/1ps
`default_nettype none

// One comparison, counted; a mismatch is reported at once
`define CHECK(what, exp, got) \
  begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end

module test_charger_control_regs
  import chgreg_pkg::*;
;
  logic              clk_sys, nrst, reg_wr, reg_rd, reg_rvalid;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [3:0]        st_in;
  logic              vbat, ichg, temp, charge_stop, comp_event, temp_event;
  chgreg_cfg_t       cfg;
  int                err_count, comparisons, cycles, comp_n, temp_n, base;

  // Places in map order; three unmapped ones close the list
  localparam logic [8:0] ADDRS [13] = '{OFS_STATE, OFS_CONTROL, OFS_CURRENT,
    OFS_VOLTAGE, OFS_PROTECT, OFS_PROTECTION_COMMAND_SPARE, OFS_WDCLR, OFS_TIMER, OFS_DISCHARGE_CONTROL,
    OFS_EXTCTL, 9'h0d8, 9'h0d0, 9'h1d0};
  localparam logic [7:0] RST_EXP [13] = '{8'h00, 8'ha1, 8'h00, 8'h07, 8'h3c,
    8'h00, 8'h00, 8'h03, 8'h04, 8'h13, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] ONES_EXP [13] = '{8'h00, 8'hef, 8'h7f, 8'h0f, 8'hfc,
    8'h00, 8'h00, 8'h0f, 8'h04, 8'h7f, 8'h00, 8'h00, 8'h00};

  chgreg_top DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .charger_state_in(st_in),
    .vbat_above_cv(vbat), .ichg_below_eoc(ichg), .temp_out_window(temp),
    .cfg(cfg), .charge_stop(charge_stop), .comp_event(comp_event),
    .temp_event(temp_event));

  // ****************************************************************
  // Clock, watchdog and pulse counters
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Pulses are one cycle wide; falling edge sees settled outputs
  always @(negedge clk_sys) begin
    cycles++;
    if (comp_event === 1'b1) comp_n++;
    if (temp_event === 1'b1) temp_n++;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end

  // ****************************************************************
  // Register access tasks
  // ****************************************************************
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Data lands on the same edge that takes the strobe
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHECK("read valid", 1'b1, reg_rvalid)
    `CHECK("read data", exp, reg_rdata)
  endtask

  // Settings trail a write by two edges
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // Lets pins pass the synchroniser and filter
  task automatic wait_pins;
    repeat (12) @(posedge clk_sys);
    #1;
  endtask

  task final_report;
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    st_in = 4'h0;
    vbat = 1'b0;
    ichg = 1'b0;
    temp = 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    // Reset values, then all-ones and all-zeros write-back
    for (int i = 0; i < 13; i++) rd(ADDRS[i], RST_EXP[i]);
    for (int i = 0; i < 13; i++) wr(ADDRS[i], 8'hff);
    for (int i = 0; i < 13; i++) rd(ADDRS[i], ONES_EXP[i]);
    for (int i = 0; i < 13; i++) wr(ADDRS[i], 8'h00);
    for (int i = 0; i < 13; i++) rd(ADDRS[i], 8'h00);
    // Field decode, first pattern
    wr(OFS_CONTROL, 8'h4e);
    wr(OFS_CURRENT, 8'h5a);
    wr(OFS_VOLTAGE, 8'h0c);
    wr(OFS_PROTECT, 8'h9c);
    wr(OFS_TIMER, 8'h0e);
    wr(OFS_DISCHARGE_CONTROL, 8'h00);
    wr(OFS_EXTCTL, 8'h2a);
    settle();
    `CHECK("charger on", 1'b1, cfg.charger_on)
    `CHECK("trickle", 1'b1, cfg.forced_trickle)
    `CHECK("watchdog", 1'b1, cfg.charge_watchdog_enable)
    `CHECK("policy", 1'b1, cfg.state_change_irq_policy)
    `CHECK("main fet", 1'b0, cfg.main_fet_allow)
    `CHECK("bypass fet", 1'b0, cfg.bypass_fet_allow)
    `CHECK("host mode", 2'b00, cfg.host_mode_sel)
    `CHECK("cc", 4'ha, cfg.const_current_setpoint)
    `CHECK("eoc", 3'h5, cfg.end_of_charge_current)
    `CHECK("cv", 4'hc, cfg.max_charge_voltage)
    `CHECK("wdt period", 2'h3, cfg.watchdog_period_sel)
    `CHECK("ov margin", 2'h1, cfg.battery_ov_margin)
    `CHECK("input limit", 2'h2, cfg.input_current_limit)
    `CHECK("safety time", 4'he, cfg.safety_time_sel)
    `CHECK("thermistor", 1'b0, cfg.thermistor_block_enable)
    `CHECK("coin on", 1'b1, cfg.backup_cell_charge_enable)
    `CHECK("coin volt", 3'h2, cfg.backup_cell_voltage_sel)
    `CHECK("slow current", 1'b1, cfg.slow_charge_current_sel)
    `CHECK("buck on", 1'b1, cfg.charger_converter_enable)
    // Field decode, opposite pattern
    wr(OFS_CONTROL, 8'ha1);
    wr(OFS_EXTCTL, 8'h41);
    wr(OFS_DISCHARGE_CONTROL, 8'h04);
    settle();
    `CHECK("charger off", 1'b0, cfg.charger_on)
    `CHECK("main fet", 1'b1, cfg.main_fet_allow)
    `CHECK("bypass fet", 1'b1, cfg.bypass_fet_allow)
    `CHECK("host mode", 2'b11, cfg.host_mode_sel)
    `CHECK("thermistor", 1'b1, cfg.thermistor_block_enable)
    `CHECK("coin off", 1'b0, cfg.backup_cell_charge_enable)
    `CHECK("coin volt", 3'h0, cfg.backup_cell_voltage_sel)
    `CHECK("slow current", 1'b0, cfg.slow_charge_current_sel)
    `CHECK("buck off", 1'b0, cfg.charger_converter_enable)
    // Thermal fault while charging, then recovery
    wr(OFS_CONTROL, 8'h00);
    base = comp_n;
    @(posedge clk_sys);
    st_in <= 4'h7;
    temp <= 1'b1;
    wait_pins();
    `CHECK("fault pulses", 1, temp_n)
    `CHECK("stop", 1'b1, charge_stop)
    `CHECK("charger on", 1'b0, cfg.charger_on)
    @(posedge clk_sys);
    st_in <= 4'h0;
    temp <= 1'b0;
    wait_pins();
    `CHECK("stop", 1'b0, charge_stop)
    `CHECK("charger on", 1'b1, cfg.charger_on)
    // Window pin while not charging stops nothing
    @(posedge clk_sys);
    st_in <= 4'h1;
    temp <= 1'b1;
    wait_pins();
    `CHECK("fault pulses", 1, temp_n)
    `CHECK("stop", 1'b0, charge_stop)
    temp <= 1'b0;
    // Completion needs both comparators under policy zero
    vbat <= 1'b1;
    wait_pins();
    `CHECK("completions", base, comp_n)
    ichg <= 1'b1;
    wait_pins();
    `CHECK("completions", base + 1, comp_n)
    vbat <= 1'b0;
    ichg <= 1'b0;
    // Policy one: every state code change flags and reads back
    wr(OFS_CONTROL, 8'h08);
    settle();
    base = comp_n;
    for (int c = 14; c >= 0; c--) begin
      @(posedge clk_sys);
      st_in <= c[3:0];
      repeat (4) @(posedge clk_sys);
      rd(OFS_STATE, {4'h0, c[3:0]});
    end
    `CHECK("state events", base + 15, comp_n)
    final_report();
  end
endmodule

bind chgreg_top chgreg_properties u_props (.clk_sys(clk_sys), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .charger_state_in(charger_state_in), .vbat_above_cv(vbat_above_cv),
  .ichg_below_eoc(ichg_below_eoc), .temp_out_window(temp_out_window),
  .cfg(cfg), .charge_stop(charge_stop), .comp_event(comp_event),
  .temp_event(temp_event));

`default_nettype wire
